// >>> verilog/smdu_consts.svh
// constants of the signed multiply / divide unit
`ifndef SMDU_CONSTS_SVH
`define SMDU_CONSTS_SVH

// word width and operand sources
`define SMDU_WORD_W 16
`define SMDU_NCHAN 8

// saturation limits of a signed result word
`define SMDU_WORD_MAX 16'h7FFF
`define SMDU_WORD_MIN 16'h8000

// reset values of result words and of the operand setup
`define SMDU_WORD_RST 16'h0000
`define SMDU_CONST_RST 16'h0000
`define SMDU_CHAN_RST 3'h0
`define SMDU_BIT_RST 1'b0

`endif

// >>> verilog/smdu_pkg.sv
// types shared by the signed multiply / divide unit
package smdu_pkg;

    // operand source codes, one-hot
    typedef enum logic [2:0] {
        SMDU_SRC_CONST  = 3'b001,
        SMDU_SRC_ANALOG = 3'b010,
        SMDU_SRC_BLOCK  = 3'b100
    } smdu_src_e;

    typedef logic [15:0] smdu_word_t;

endpackage

// >>> verilog/smdu_opsel.sv
// operand selector: holds one operand setup and picks constant, analog channel or block word
`timescale 1ns/1ps
`include "smdu_consts.svh"

module smdu_opsel
    import smdu_pkg::*;
#(
    parameter int W = `SMDU_WORD_W,
    parameter int NCH = `SMDU_NCHAN
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // setup load
    input wire logic load,
    input wire logic [2:0] src_in,
    input wire logic [W-1:0] const_in,
    input wire logic [$clog2(NCH)-1:0] chan_in,
    // live sources
    input wire logic [NCH*W-1:0] analog,
    input wire logic [W-1:0] block_word,
    // chosen operand
    output logic [W-1:0] operand
);

    typedef struct packed {
        smdu_src_e src;
        logic [W-1:0] cval;
        logic [$clog2(NCH)-1:0] chan;
    } smdu_opsel_s;

    smdu_opsel_s st;
    smdu_opsel_s next_st;

    // ==========================================
    // setup register
    always_comb begin
        next_st = st;
        if (load) begin
            // an illegal source code keeps the previous source, the rest still loads
            if (src_in == SMDU_SRC_CONST || src_in == SMDU_SRC_ANALOG || src_in == SMDU_SRC_BLOCK) begin
                next_st.src = smdu_src_e'(src_in);
            end
            next_st.cval = const_in;
            next_st.chan = chan_in;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st.src <= SMDU_SRC_CONST; // [RULE_02]
            st.cval <= W'(`SMDU_CONST_RST); // [RULE_02]
            st.chan <= ($clog2(NCH))'(`SMDU_CHAN_RST); // [RULE_03]
        end else if (ce) begin
            st <= next_st;
        end
    end

    // ==========================================
    // operand multiplexer
    always_comb begin
        operand = '0;
        unique case (st.src)
            SMDU_SRC_CONST: operand = st.cval; // [RULE_02]
            SMDU_SRC_ANALOG: operand = analog[st.chan*W +: W]; // [RULE_03]
            SMDU_SRC_BLOCK: operand = block_word; // [RULE_04]
        endcase
    end

endmodule

// >>> verilog/smdu_top.sv
// signed 16-bit multiply unit and divide unit with hold, saturation and error bits
//
// What this block does
// RULE_01 - The multiply unit outputs the product of operand A and operand B as its word.
// RULE_02 - Every operand can be a signed constant from -32768 to +32767 that is 0 after reset.
// RULE_03 - Every operand can instead be one of eight analog channels, the first channel after reset.
// RULE_04 - Every operand can instead be the word output of another function block.
// RULE_05 - With its enable high the multiply unit evaluates and updates its word each scan.
// RULE_06 - With its enable low the multiply unit holds its last word.
// RULE_07 - A product below -32768 gives -32768 and a high error bit.
// RULE_08 - A product above 32767 gives 32767 and a high error bit.
// RULE_09 - The divide unit outputs the quotient A/B and the remainder A%B.
// RULE_10 - With its enable high the divide unit evaluates and updates both words each scan.
// RULE_11 - With its enable low the divide unit holds both last words.
// RULE_12 - A zero divisor forces quotient and remainder to 0 and raises the error bit.
// RULE_13 - A quotient above 32767 is clamped to 32767 and raises the error bit.
// RULE_14 - All words are 16-bit two's complement and one evaluation happens per enabled scan cycle.
// RULE_15 - A clean enabled evaluation clears the error bit, and division truncates toward zero.
`timescale 1ns/1ps
`include "smdu_consts.svh"

module smdu_top
    import smdu_pkg::*;
#(
    parameter int W = `SMDU_WORD_W,
    parameter int NCH = `SMDU_NCHAN
) (
    // clock, reset, clock enable
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic CE,
    // live operand sources
    input wire logic [NCH*W-1:0] ANALOG_IN,
    input wire logic [W-1:0] MUL_A_BLOCK,
    input wire logic [W-1:0] MUL_B_BLOCK,
    input wire logic [W-1:0] DIV_A_BLOCK,
    input wire logic [W-1:0] DIV_B_BLOCK,
    // operand setup, loaded on CFG_LOAD
    input wire logic CFG_LOAD,
    input wire logic [2:0] MUL_A_SRC,
    input wire logic [W-1:0] MUL_A_CONST,
    input wire logic [$clog2(NCH)-1:0] MUL_A_CHAN,
    input wire logic [2:0] MUL_B_SRC,
    input wire logic [W-1:0] MUL_B_CONST,
    input wire logic [$clog2(NCH)-1:0] MUL_B_CHAN,
    input wire logic [2:0] DIV_A_SRC,
    input wire logic [W-1:0] DIV_A_CONST,
    input wire logic [$clog2(NCH)-1:0] DIV_A_CHAN,
    input wire logic [2:0] DIV_B_SRC,
    input wire logic [W-1:0] DIV_B_CONST,
    input wire logic [$clog2(NCH)-1:0] DIV_B_CHAN,
    // enable pins of the two units
    input wire logic MUL_EN,
    input wire logic DIV_EN,
    // multiply results
    output logic [W-1:0] MUL_Y,
    output logic MUL_ERR,
    output logic MUL_UPD,
    // divide results
    output logic [W-1:0] DIV_Q,
    output logic [W-1:0] DIV_R,
    output logic DIV_ERR,
    output logic DIV_ZERO,
    output logic DIV_UPD
);

    typedef struct packed {
        logic [W-1:0] mul_y;
        logic mul_err;
        logic mul_upd;
        logic [W-1:0] div_q;
        logic [W-1:0] div_r;
        logic div_err;
        logic div_zero;
        logic div_upd;
    } smdu_state_s;

    smdu_state_s st;
    smdu_state_s next_st;

    logic [W-1:0] mul_a;
    logic [W-1:0] mul_b;
    logic [W-1:0] div_a;
    logic [W-1:0] div_b;

    // ==========================================
    // saturation of a wide signed value to one word; the flag marks a clamp
    function automatic logic [W:0] sat_word(input logic signed [2*W:0] v);
        logic signed [2*W:0] hi;
        logic signed [2*W:0] lo;
        hi = (2*W+1)'(signed'(W'(`SMDU_WORD_MAX)));
        lo = (2*W+1)'(signed'(W'(`SMDU_WORD_MIN)));
        if (v > hi) begin
            sat_word = {1'b1, W'(`SMDU_WORD_MAX)}; // [RULE_08] [RULE_13]
        end else if (v < lo) begin
            sat_word = {1'b1, W'(`SMDU_WORD_MIN)}; // [RULE_07]
        end else begin
            sat_word = {1'b0, v[W-1:0]};
        end
    endfunction

    // ==========================================
    // sign extension of one word to the width of the wide arithmetic
    function automatic logic signed [2*W:0] widen(input logic [W-1:0] w);
        widen = $signed({{(W+1){w[W-1]}}, w});
    endfunction

    // ==========================================
    // operand selectors
    smdu_opsel #(.W(W), .NCH(NCH)) u_mul_a (
        .clk(CLK),
        .rst_b(RST_B),
        .ce(CE),
        .load(CFG_LOAD),
        .src_in(MUL_A_SRC),
        .const_in(MUL_A_CONST),
        .chan_in(MUL_A_CHAN),
        .analog(ANALOG_IN),
        .block_word(MUL_A_BLOCK),
        .operand(mul_a)
    );

    smdu_opsel #(.W(W), .NCH(NCH)) u_mul_b (
        .clk(CLK),
        .rst_b(RST_B),
        .ce(CE),
        .load(CFG_LOAD),
        .src_in(MUL_B_SRC),
        .const_in(MUL_B_CONST),
        .chan_in(MUL_B_CHAN),
        .analog(ANALOG_IN),
        .block_word(MUL_B_BLOCK),
        .operand(mul_b)
    );

    smdu_opsel #(.W(W), .NCH(NCH)) u_div_a (
        .clk(CLK),
        .rst_b(RST_B),
        .ce(CE),
        .load(CFG_LOAD),
        .src_in(DIV_A_SRC),
        .const_in(DIV_A_CONST),
        .chan_in(DIV_A_CHAN),
        .analog(ANALOG_IN),
        .block_word(DIV_A_BLOCK),
        .operand(div_a)
    );

    smdu_opsel #(.W(W), .NCH(NCH)) u_div_b (
        .clk(CLK),
        .rst_b(RST_B),
        .ce(CE),
        .load(CFG_LOAD),
        .src_in(DIV_B_SRC),
        .const_in(DIV_B_CONST),
        .chan_in(DIV_B_CHAN),
        .analog(ANALOG_IN),
        .block_word(DIV_B_BLOCK),
        .operand(div_b)
    );

    // ==========================================
    // evaluation, one step per enabled clock
    always_comb begin
        logic signed [2*W:0] prod;
        logic signed [2*W:0] qa;
        logic signed [2*W:0] qb;
        logic signed [2*W:0] quo;
        logic signed [2*W:0] rem;
        logic [W:0] msat;
        logic [W:0] qsat;
        // widen by sign so that -32768 / -1 is seen as 32768 and not wrapped
        prod = widen(mul_a) * widen(mul_b); // [RULE_01] [RULE_14]
        qa = widen(div_a);
        qb = widen(div_b);
        quo = '0;
        rem = '0;
        if (div_b != '0) begin
            // signed / and % truncate toward zero, remainder takes the dividend's sign
            quo = qa / qb; // [RULE_09] [RULE_15]
            rem = qa % qb; // [RULE_09] [RULE_15]
        end
        msat = sat_word(prod);
        qsat = sat_word(quo);
        next_st = st;
        next_st.mul_upd = 1'b0;
        next_st.div_upd = 1'b0;
        if (MUL_EN) begin
            next_st.mul_y = msat[W-1:0]; // [RULE_05] [RULE_07] [RULE_08]
            next_st.mul_err = msat[W]; // [RULE_07] [RULE_08] [RULE_15]
            next_st.mul_upd = 1'b1; // [RULE_14]
        end
        // with the enable low only the update pulse is written (cleared), so every result word holds [RULE_06] [RULE_11]
        if (DIV_EN) begin
            next_st.div_upd = 1'b1; // [RULE_14]
            if (div_b == '0) begin
                next_st.div_q = W'(`SMDU_WORD_RST); // [RULE_12]
                next_st.div_r = W'(`SMDU_WORD_RST); // [RULE_12]
                next_st.div_err = 1'b1; // [RULE_12]
                next_st.div_zero = 1'b1;
            end else begin
                next_st.div_q = qsat[W-1:0]; // [RULE_10] [RULE_13]
                next_st.div_r = rem[W-1:0]; // [RULE_10]
                next_st.div_err = qsat[W]; // [RULE_13] [RULE_15]
                next_st.div_zero = 1'b0;
            end
        end
    end

    // ==========================================
    // state register; CE low freezes everything, pulses included
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            st.mul_y <= W'(`SMDU_WORD_RST);
            st.mul_err <= `SMDU_BIT_RST;
            st.mul_upd <= `SMDU_BIT_RST;
            st.div_q <= W'(`SMDU_WORD_RST);
            st.div_r <= W'(`SMDU_WORD_RST);
            st.div_err <= `SMDU_BIT_RST;
            st.div_zero <= `SMDU_BIT_RST;
            st.div_upd <= `SMDU_BIT_RST;
        end else if (CE) begin
            st <= next_st; // [RULE_05] [RULE_10]
        end
    end

    // ==========================================
    // outputs straight from the state register
    assign MUL_Y = st.mul_y;
    assign MUL_ERR = st.mul_err;
    assign MUL_UPD = st.mul_upd;
    assign DIV_Q = st.div_q;
    assign DIV_R = st.div_r;
    assign DIV_ERR = st.div_err;
    assign DIV_ZERO = st.div_zero;
    assign DIV_UPD = st.div_upd;

endmodule

// >>> bench/smdu_src_model.sv
// far-side sources: analog channels and neighbouring block words
`timescale 1ns/1ps
module smdu_src_model (
    // analog channels, first channel in the lowest word
    output logic [127:0] analog,
    // word outputs of neighbouring blocks
    output logic [15:0] mul_b_word,
    output logic [15:0] div_b_word
);
    // ==========================================
    // levels
    // distinct level per channel so a wrong index shows
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            analog[k*16 +: 16] = 16'h0100 + 16'(k);
        end
    end
    assign mul_b_word = 16'hFFFE;
    assign div_b_word = 16'h0005;
endmodule

// >>> bench/smdu_top_sva.sv
// assertion checker for the signed multiply / divide unit
`timescale 1ns/1ps
module smdu_top_sva (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic CE,
    // enables
    input wire logic MUL_EN,
    input wire logic DIV_EN,
    // results
    input wire logic [15:0] MUL_Y,
    input wire logic MUL_ERR,
    input wire logic MUL_UPD,
    input wire logic [15:0] DIV_Q,
    input wire logic [15:0] DIV_R,
    input wire logic DIV_ERR,
    input wire logic DIV_ZERO,
    input wire logic DIV_UPD
);
    // ==========================================
    // properties
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);
    property p_mul_upd; CE && MUL_EN |=> MUL_UPD; endproperty
    a_mul_upd: assert property (p_mul_upd) else $error("mul eval missing");
    property p_div_upd; CE && DIV_EN |=> DIV_UPD; endproperty
    a_div_upd: assert property (p_div_upd) else $error("div eval missing");
    property p_mul_hold; CE && !MUL_EN |=> $stable(MUL_Y) && $stable(MUL_ERR) && !MUL_UPD; endproperty
    a_mul_hold: assert property (p_mul_hold) else $error("mul not held");
    property p_div_hold; CE && !DIV_EN |=> $stable(DIV_Q) && $stable(DIV_R) && $stable(DIV_ERR) && !DIV_UPD;
    endproperty
    a_div_hold: assert property (p_div_hold) else $error("div not held");
    property p_freeze; !CE |=> $stable(MUL_Y) && $stable(DIV_Q) && $stable(MUL_UPD); endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");
    property p_mul_sat; MUL_UPD && MUL_ERR |-> MUL_Y inside {16'h7FFF, 16'h8000}; endproperty
    a_mul_sat: assert property (p_mul_sat) else $error("mul error without clamp");
    property p_div_zero; DIV_UPD && DIV_ZERO |-> DIV_ERR && DIV_Q == 16'h0000 && DIV_R == 16'h0000; endproperty
    a_div_zero: assert property (p_div_zero) else $error("zero divisor result wrong");
    property p_div_ovf; DIV_ERR && !DIV_ZERO |-> DIV_Q == 16'h7FFF; endproperty
    a_div_ovf: assert property (p_div_ovf) else $error("quotient clamp wrong");
    c_mul_sat: cover property (MUL_UPD && MUL_ERR);
    c_div_zero: cover property (DIV_UPD && DIV_ZERO);
    c_freeze: cover property (!CE ##1 CE);
endmodule

bind smdu_top smdu_top_sva u_sva (.CLK, .RST_B, .CE, .MUL_EN, .DIV_EN, .MUL_Y, .MUL_ERR, .MUL_UPD,
    .DIV_Q, .DIV_R, .DIV_ERR, .DIV_ZERO, .DIV_UPD);

// >>> bench/test_smdu_top.sv
// self-checking bench of the signed multiply / divide unit
`timescale 1ns/1ps
module test_smdu_top;
    // ==========================================
    // wiring
    logic clk, rst_b, ce, cfg_load, mul_en, div_en;
    logic [2:0] src [4];
    logic [15:0] cst [4];
    logic [2:0] chn [4];
    logic [127:0] analog;
    logic [15:0] mwb, dwb, mul_y, div_q, div_r;
    logic mul_err, mul_upd, div_err, div_zero, div_upd;
    int error_cnt = 0;
    int total_checks = 0;
    smdu_src_model far (.analog(analog), .mul_b_word(mwb), .div_b_word(dwb));
    smdu_top dut (.CLK(clk), .RST_B(rst_b), .CE(ce), .ANALOG_IN(analog), .MUL_A_BLOCK(mwb), .MUL_B_BLOCK(mwb),
        .DIV_A_BLOCK(dwb), .DIV_B_BLOCK(dwb), .CFG_LOAD(cfg_load),
        .MUL_A_SRC(src[0]), .MUL_A_CONST(cst[0]), .MUL_A_CHAN(chn[0]),
        .MUL_B_SRC(src[1]), .MUL_B_CONST(cst[1]), .MUL_B_CHAN(chn[1]),
        .DIV_A_SRC(src[2]), .DIV_A_CONST(cst[2]), .DIV_A_CHAN(chn[2]),
        .DIV_B_SRC(src[3]), .DIV_B_CONST(cst[3]), .DIV_B_CHAN(chn[3]), .MUL_EN(mul_en), .DIV_EN(div_en),
        .MUL_Y(mul_y), .MUL_ERR(mul_err), .MUL_UPD(mul_upd), .DIV_Q(div_q), .DIV_R(div_r),
        .DIV_ERR(div_err), .DIV_ZERO(div_zero), .DIV_UPD(div_upd));
    // ==========================================
    // helpers
    task chk_w(input logic [15:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task chk_b(input logic got, exp);
        chk_w({15'h0000, got}, {15'h0000, exp});
    endtask
    // same source for both A operands and for both B operands
    task load(input logic [2:0] sa, sb, input logic [15:0] c0, c1, c2, c3);
        @(posedge clk);
        src <= '{sa, sb, sa, sb};
        cst <= '{c0, c1, c2, c3};
        cfg_load <= 1'b1;
        @(posedge clk);
        cfg_load <= 1'b0;
    endtask
    // one enabled edge, results looked at mid-cycle after it
    task eval(input logic m, d);
        @(posedge clk);
        mul_en <= m;
        div_en <= d;
        @(posedge clk);
        mul_en <= 1'b0;
        div_en <= 1'b0;
        @(negedge clk);
    endtask
    task conclude;
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ==========================================
    // scenarios
    task t_defaults;
        eval(1'b1, 1'b1);
        chk_w(mul_y, 16'h0000);
        chk_b(mul_err, 1'b0);
        chk_b(div_zero, 1'b1);
        chk_b(div_err, 1'b1);
        chk_b(mul_upd, 1'b1);
        chk_b(div_upd, 1'b1);
    endtask
    task automatic t_mul;
        logic [15:0] a [4] = '{16'h012C, 16'hFED4, 16'hFFF9, 16'h8000};
        logic [15:0] b [4] = '{16'h00C8, 16'h00C8, 16'h0005, 16'h0001};
        logic [15:0] y [4] = '{16'h7FFF, 16'h8000, 16'hFFDD, 16'h8000};
        logic e [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
        for (int i = 0; i < 4; i++) begin
            load(3'b001, 3'b001, a[i], b[i], 16'h0000, 16'h0001);
            eval(1'b1, 1'b0);
            chk_w(mul_y, y[i]);
            chk_b(mul_err, e[i]);
        end
    endtask
    task automatic t_div;
        logic [15:0] a [4] = '{16'hFFF9, 16'h0007, 16'h8000, 16'h0064};
        logic [15:0] b [4] = '{16'h0002, 16'h0000, 16'hFFFF, 16'h0007};
        logic [15:0] q [4] = '{16'hFFFD, 16'h0000, 16'h7FFF, 16'h000E};
        logic [15:0] r [4] = '{16'hFFFF, 16'h0000, 16'h0000, 16'h0002};
        logic e [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
        for (int i = 0; i < 4; i++) begin
            load(3'b001, 3'b001, 16'h0000, 16'h0000, a[i], b[i]);
            eval(1'b0, 1'b1);
            chk_w(div_q, q[i]);
            chk_w(div_r, r[i]);
            chk_b(div_err, e[i]);
        end
    endtask
    task t_src;
        @(posedge clk);
        chn <= '{3'h3, 3'h0, 3'h7, 3'h0};
        load(3'b010, 3'b100, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
        eval(1'b1, 1'b1);
        chk_w(mul_y, 16'hFDFA);
        chk_w(div_q, 16'h0034);
        chk_w(div_r, 16'h0003);
    endtask
    task t_hold;
        load(3'b001, 3'b001, 16'h0002, 16'h0003, 16'h0009, 16'h0002);
        repeat (3) @(posedge clk);
        ce <= 1'b0;
        mul_en <= 1'b1;
        div_en <= 1'b1;
        repeat (2) @(posedge clk);
        ce <= 1'b1;
        mul_en <= 1'b0;
        div_en <= 1'b0;
        @(negedge clk);
        chk_w(mul_y, 16'hFDFA);
        chk_b(mul_upd, 1'b0);
        chk_w(div_q, 16'h0034);
        eval(1'b1, 1'b1);
        chk_w(mul_y, 16'h0006);
        chk_w(div_r, 16'h0001);
        chk_w(div_q, 16'h0004);
    endtask
    // ==========================================
    // run
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        rst_b = 1'b0;
        ce = 1'b1;
        cfg_load = 1'b0;
        mul_en = 1'b0;
        div_en = 1'b0;
        src = '{default: 3'b001};
        cst = '{default: 16'h0000};
        chn = '{default: 3'h0};
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        t_defaults();
        t_mul();
        t_div();
        t_src();
        t_hold();
        conclude();
    end
    // whole run needs well under 200 cycles
    initial begin
        repeat (2000) @(posedge clk);
        error_cnt++;
        conclude();
    end
endmodule
